// file: hw/fapr_page_capture.sv
// Capture of received base and next pages and the partner expansion flags.
`timescale 1ns/1ps
module fapr_page_capture
    import fapr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Page traffic.
    fapr_page_if.capture pg
);
    logic [15:0] ability_reg;
    logic [15:0] partner_np_reg;
    logic        np_able_reg;
    logic        neg_able_reg;
    logic        base_rx;
    logic        next_rx;

    assign base_rx = pg.page_valid & ~pg.page_is_next;
    assign next_rx = pg.page_valid & pg.page_is_next;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ability_reg <= FAPR_ABIL_RST;
        end else if (base_rx) begin
            ability_reg <= pg.page_word & FAPR_ABIL_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            partner_np_reg <= FAPR_LPNP_RST;
        end else if (next_rx) begin
            partner_np_reg <= pg.page_word & FAPR_LPNP_MASK;
        end
    end

    // A page arriving in the cycle the enable state is entered still sets its flag.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            np_able_reg <= 1'b0;
        end else if (base_rx && pg.page_word[FAPR_NP_BIT]) begin
            np_able_reg <= 1'b1;
        end else if (pg.enable_enter) begin
            np_able_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            neg_able_reg <= 1'b0;
        end else if (base_rx) begin
            neg_able_reg <= 1'b1;
        end else if (pg.enable_enter) begin
            neg_able_reg <= 1'b0;
        end
    end

    assign pg.ability    = ability_reg;
    assign pg.partner_np = partner_np_reg;
    assign pg.np_able    = np_able_reg;
    assign pg.neg_able   = neg_able_reg;
endmodule

// file: hw/fapr_page_if.sv
// Interface carrying received pages into the capture logic and the captured contents back.
`timescale 1ns/1ps
interface fapr_page_if;
    logic        page_valid;
    logic        page_is_next;
    logic [15:0] page_word;
    logic        enable_enter;
    logic [15:0] ability;
    logic [15:0] partner_np;
    logic        np_able;
    logic        neg_able;

    modport capture (
        input  page_valid,
        input  page_is_next,
        input  page_word,
        input  enable_enter,
        output ability,
        output partner_np,
        output np_able,
        output neg_able
    );
    modport top (
        output page_valid,
        output page_is_next,
        output page_word,
        output enable_enter,
        input  ability,
        input  partner_np,
        input  np_able,
        input  neg_able
    );
endinterface

// file: hw/fapr_pkg.sv
// Package with register indices, field positions and reset values of the page register bank.
package fapr_pkg;
    // Register indices; the bus byte address is four times the index.
    localparam logic [11:0] FAPR_ABIL_IDX  = 12'hc05;
    localparam logic [11:0] FAPR_EXP_IDX   = 12'hc06;
    localparam logic [11:0] FAPR_LOCNP_IDX = 12'hc07;
    localparam logic [11:0] FAPR_LPNP_IDX  = 12'hc08;
    localparam logic [11:0] FAPR_ISTS_IDX  = 12'hc20;
    localparam logic [11:0] FAPR_IMSK_IDX  = 12'hc21;
    localparam int          FAPR_IDX_LSB   = 2;
    localparam int          FAPR_IDX_MSB   = 13;

    // Page word field positions.
    localparam int FAPR_NP_BIT     = 15;
    localparam int FAPR_ACK_BIT    = 14;
    localparam int FAPR_MSG_BIT    = 13;
    localparam int FAPR_ACK2_BIT   = 12;
    localparam int FAPR_TOGGLE_BIT = 11;

    // Expansion register field positions.
    localparam int FAPR_EXP_NPABLE  = 3;
    localparam int FAPR_EXP_LOCNP   = 2;
    localparam int FAPR_EXP_ARRIVED = 1;
    localparam int FAPR_EXP_NEG     = 0;

    // Readable bits of the partner ability and partner next page registers.
    localparam logic [15:0] FAPR_ABIL_MASK     = 16'hf1e0;
    localparam logic [15:0] FAPR_LPNP_MASK     = 16'hbfff;
    // Software-writable bits of the local next page register.
    localparam logic [15:0] FAPR_LOCNP_WR_MASK = 16'hb7ff;

    // Reset values.
    localparam logic [15:0] FAPR_ABIL_RST  = 16'h0000;
    localparam logic [15:0] FAPR_LPNP_RST  = 16'h0000;
    localparam logic [15:0] FAPR_LOCNP_RST = 16'h2001;
    localparam logic [1:0]  FAPR_INT_RST   = 2'h0;

    // Interrupt status and mask bits.
    localparam int FAPR_INT_BP = 0;
    localparam int FAPR_INT_NP = 1;
    localparam int FAPR_INT_W  = 2;

    // AHB transfer type.
    localparam logic [1:0] FAPR_HTRANS_NONSEQ = 2'h2;

    typedef enum logic [0:0] {
        FAPR_PH_IDLE,
        FAPR_PH_WRITE
    } fapr_phase_e;
endpackage

// file: hw/fapr_regs.sv
// Fiber auto-negotiation page register bank with AHB-Lite slave and interrupt.
`timescale 1ns/1ps
module fapr_regs
    import fapr_pkg::*;
(
    // Clock and reset.
    input  wire logic        MCLK,
    input  wire logic        RESETN,
    // AHB-Lite slave.
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // Received pages from the negotiation logic.
    input  wire logic        PAGE_VALID,
    input  wire logic        PAGE_IS_NEXT,
    input  wire logic [15:0] PAGE_WORD,
    input  wire logic        NEGOTIATION_ENABLE_STATE,
    // Operating mode: high for SGMII, low for fiber 1000BASE-X.
    input  wire logic        SGMII_MODE,
    // Local next page toward the transmitter.
    input  wire logic        LOCAL_PAGE_SENT,
    output logic      [15:0] LOCAL_PAGE_WORD,
    // Interrupt.
    output logic             IRQ
);
    fapr_page_if pg ();

    fapr_phase_e phase_reg;
    logic [11:0] wr_idx_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [15:0] locnp_reg;
    logic        toggle_reg;
    logic        arrived_reg;
    logic [FAPR_INT_W-1:0] ists_reg;
    logic [FAPR_INT_W-1:0] imsk_reg;
    logic [FAPR_INT_W-1:0] int_event;
    logic [11:0] a_idx;
    logic        a_valid;
    logic        rd_take;
    logic        wr_take;
    logic        wr_do;
    logic [15:0] exp_word;
    logic [15:0] locnp_word;

    // Decodes a register index into one of the mapped registers.
    function automatic logic idx_is(input logic [11:0] idx, input logic [11:0] reg_idx);
        idx_is = (idx == reg_idx);
    endfunction

    assign pg.page_valid   = PAGE_VALID;
    assign pg.page_is_next = PAGE_IS_NEXT;
    assign pg.page_word    = PAGE_WORD;
    assign pg.enable_enter = NEGOTIATION_ENABLE_STATE;

    fapr_page_capture u_capture (
        .clk   (MCLK),
        .rst_n (RESETN),
        .pg    (pg.capture)
    );

    // Address phase decode; the slave never inserts wait states.
    assign a_idx   = HADDR[FAPR_IDX_MSB:FAPR_IDX_LSB];
    assign a_valid = HSEL & HREADY & (HTRANS == FAPR_HTRANS_NONSEQ);
    assign rd_take = a_valid & ~HWRITE;
    assign wr_take = a_valid & HWRITE;
    assign wr_do   = (phase_reg == FAPR_PH_WRITE);

    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            phase_reg <= FAPR_PH_IDLE;
        end else begin
            case (phase_reg)
                FAPR_PH_IDLE: begin
                    if (wr_take) begin
                        phase_reg <= FAPR_PH_WRITE;
                    end
                end
                FAPR_PH_WRITE: begin
                    if (!wr_take) begin
                        phase_reg <= FAPR_PH_IDLE;
                    end
                end
                default: begin
                    phase_reg <= FAPR_PH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            wr_idx_reg <= 12'h000;
        end else if (wr_take) begin
            wr_idx_reg <= a_idx;
        end
    end

    // Expansion word as software sees it.
    always_comb begin
        exp_word                   = 16'h0000;
        exp_word[FAPR_EXP_NPABLE]  = pg.np_able;
        exp_word[FAPR_EXP_LOCNP]   = ~SGMII_MODE;
        exp_word[FAPR_EXP_ARRIVED] = arrived_reg;
        exp_word[FAPR_EXP_NEG]     = pg.neg_able;
    end

    // Local next page word with the hardware-kept toggle inserted.
    always_comb begin
        locnp_word                  = locnp_reg;
        locnp_word[FAPR_TOGGLE_BIT] = toggle_reg;
    end

    assign LOCAL_PAGE_WORD = locnp_word;

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (idx_is(a_idx, FAPR_ABIL_IDX)) begin
            rdata_next[15:0] = pg.ability;
        end else if (idx_is(a_idx, FAPR_EXP_IDX)) begin
            rdata_next[15:0] = exp_word;
        end else if (idx_is(a_idx, FAPR_LOCNP_IDX)) begin
            rdata_next[15:0] = locnp_word;
        end else if (idx_is(a_idx, FAPR_LPNP_IDX)) begin
            rdata_next[15:0] = pg.partner_np;
        end else if (idx_is(a_idx, FAPR_ISTS_IDX)) begin
            rdata_next[FAPR_INT_W-1:0] = ists_reg;
        end else if (idx_is(a_idx, FAPR_IMSK_IDX)) begin
            rdata_next[FAPR_INT_W-1:0] = imsk_reg;
        end
    end

    // Read data is registered at the address phase and stands through the data phase.
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_take) begin
            rdata_reg <= rdata_next;
        end
    end

    assign HRDATA = rdata_reg;

    // Local next page: only the software-owned fields take a write.
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            locnp_reg <= FAPR_LOCNP_RST;
        end else if (wr_do && idx_is(wr_idx_reg, FAPR_LOCNP_IDX)) begin
            locnp_reg <= HWDATA[15:0] & FAPR_LOCNP_WR_MASK;
        end
    end

    // Each transmitted page carries the current toggle; the next one carries its inverse.
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            toggle_reg <= 1'b0;
        end else if (LOCAL_PAGE_SENT) begin
            toggle_reg <= ~toggle_reg;
        end
    end

    // Page-arrived flag: a page in the same cycle as the clearing read keeps it set.
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            arrived_reg <= 1'b0;
        end else if (PAGE_VALID) begin
            arrived_reg <= 1'b1;
        end else if (rd_take && idx_is(a_idx, FAPR_EXP_IDX)) begin
            arrived_reg <= 1'b0;
        end
    end

    assign int_event[FAPR_INT_BP] = PAGE_VALID & ~PAGE_IS_NEXT;
    assign int_event[FAPR_INT_NP] = PAGE_VALID & PAGE_IS_NEXT;

    // Sticky status, write one to clear; a new event wins over the clear.
    genvar gi;
    generate
        for (gi = 0; gi < FAPR_INT_W; gi++) begin : g_ists
            always_ff @(posedge MCLK or negedge RESETN) begin
                if (!RESETN) begin
                    ists_reg[gi] <= FAPR_INT_RST[gi];
                end else if (int_event[gi]) begin
                    ists_reg[gi] <= 1'b1;
                end else if (wr_do && idx_is(wr_idx_reg, FAPR_ISTS_IDX) && HWDATA[gi]) begin
                    ists_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            imsk_reg <= FAPR_INT_RST;
        end else if (wr_do && idx_is(wr_idx_reg, FAPR_IMSK_IDX)) begin
            imsk_reg <= HWDATA[FAPR_INT_W-1:0];
        end
    end

    assign IRQ = |(ists_reg & imsk_reg);
endmodule

// file: tb/fapr_partner.sv
// Link partner model that delivers one received page per call.
`timescale 1ns/1ps
module fapr_partner (
    // Clock and mode.
    input  wire logic   clk,
    input  wire logic   sgmii,
    // Page delivery.
    output logic        page_valid,
    output logic        page_is_next,
    output logic [15:0] page_word
);
    initial begin
        page_valid   = 1'b0;
        page_is_next = 1'b0;
        page_word    = 16'h0;
    end
    task automatic send(input logic nxt, input logic [15:0] w);
        logic [15:0] v;
        v = w;
        if (sgmii && !nxt) begin
            v[15] = 1'b0;
        end
        page_valid   <= 1'b1;
        page_is_next <= nxt;
        page_word    <= v;
        @(posedge clk);
        page_valid <= 1'b0;
        page_word  <= ~v;
    endtask
endmodule

// file: tb/fapr_regs_chk.sv
// Checker of the page register bank at its ports.
`timescale 1ns/1ps
module fapr_regs_chk
    import fapr_pkg::*;
(
    // Clock, reset and bus.
    input wire logic        MCLK,
    input wire logic        RESETN,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    // Pages, mode and local page.
    input wire logic        PAGE_VALID,
    input wire logic        PAGE_IS_NEXT,
    input wire logic [15:0] PAGE_WORD,
    input wire logic        NEGOTIATION_ENABLE_STATE,
    input wire logic        SGMII_MODE,
    input wire logic        LOCAL_PAGE_SENT,
    input wire logic [15:0] LOCAL_PAGE_WORD
);
    logic        rd;
    logic        wr;
    logic        bp;
    logic [11:0] ix;
    assign rd = HSEL && HREADY && HTRANS == FAPR_HTRANS_NONSEQ && !HWRITE;
    assign wr = HSEL && HREADY && HTRANS == FAPR_HTRANS_NONSEQ && HWRITE;
    assign ix = HADDR[13:2];
    assign bp = PAGE_VALID && !PAGE_IS_NEXT;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    property p_abil;
        bp ##1 rd && ix == FAPR_ABIL_IDX |=>
            HRDATA == {16'h0, $past(PAGE_WORD, 2) & FAPR_ABIL_MASK};
    endproperty
    a_abil: assert property (p_abil)
        else $error("Ability read differs from base page.");
    property p_lpnp;
        PAGE_VALID && PAGE_IS_NEXT ##1 rd && ix == FAPR_LPNP_IDX |=>
            HRDATA == {16'h0, $past(PAGE_WORD, 2) & FAPR_LPNP_MASK};
    endproperty
    a_lpnp: assert property (p_lpnp)
        else $error("Partner next page read differs.");
    property p_exp;
        bp ##1 rd && ix == FAPR_EXP_IDX |=>
            HRDATA[1:0] == 2'h3 && (HRDATA[3] || !$past(PAGE_WORD[15], 2));
    endproperty
    a_exp: assert property (p_exp)
        else $error("Expansion flags not set by base page.");
    property p_loc;
        rd && ix == FAPR_EXP_IDX |=> HRDATA[2] == !$past(SGMII_MODE);
    endproperty
    a_loc: assert property (p_loc)
        else $error("Local next page able flag wrong.");
    property p_clr;
        rd && ix == FAPR_EXP_IDX && !PAGE_VALID ##1 !PAGE_VALID ##1
            rd && ix == FAPR_EXP_IDX |=> !HRDATA[1];
    endproperty
    a_clr: assert property (p_clr)
        else $error("Page arrived flag not cleared by read.");
    property p_en;
        NEGOTIATION_ENABLE_STATE && !PAGE_VALID ##1 rd && ix == FAPR_EXP_IDX
            |=> !HRDATA[3] && !HRDATA[0];
    endproperty
    a_en: assert property (p_en)
        else $error("Enable state did not clear flags.");
    // A write to the local page shows on the transmit word one edge after its data phase.
    property p_word;
        wr && ix == FAPR_LOCNP_IDX ##1 1'b1 |=>
            (LOCAL_PAGE_WORD & FAPR_LOCNP_WR_MASK) ==
            ($past(HWDATA[15:0]) & FAPR_LOCNP_WR_MASK);
    endproperty
    a_word: assert property (p_word)
        else $error("Local page word differs from written value.");
    property p_tog;
        1'b1 |=> LOCAL_PAGE_WORD[11] == ($past(LOCAL_PAGE_WORD[11]) ^ $past(LOCAL_PAGE_SENT));
    endproperty
    a_tog: assert property (p_tog)
        else $error("Local toggle bit wrong.");
    c_base: cover property (bp ##1 rd);
    c_next: cover property (PAGE_VALID && PAGE_IS_NEXT);
    c_sent: cover property (LOCAL_PAGE_SENT);
endmodule
bind fapr_regs fapr_regs_chk fapr_regs_chk_i (.MCLK, .RESETN, .HSEL, .HADDR, .HTRANS,
    .HWRITE, .HWDATA, .HREADY, .HRDATA, .PAGE_VALID, .PAGE_IS_NEXT, .PAGE_WORD,
    .NEGOTIATION_ENABLE_STATE, .SGMII_MODE, .LOCAL_PAGE_SENT, .LOCAL_PAGE_WORD);

// file: tb/fapr_regs_test.sv
// Self-checking bench of the page register bank.
`timescale 1ns/1ps
module fapr_regs_test;
    import fapr_pkg::*;
    logic        mclk, resetn, hsel, hwrite, pv, pn, en_st, sgmii, sent;
    logic        hready, hresp, irq, tog, np, sg;
    logic [31:0] haddr, hwdata, hrdata, d, w;
    logic [1:0]  htrans;
    logic [15:0] pw, lpw;
    int          n_mismatch, n_checks, i, seed;
    fapr_partner fapr_partner_i (.clk(mclk), .sgmii(sgmii), .page_valid(pv),
        .page_is_next(pn), .page_word(pw));
    fapr_regs fapr_regs_i (.MCLK(mclk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
        .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .PAGE_VALID(pv),
        .PAGE_IS_NEXT(pn), .PAGE_WORD(pw), .NEGOTIATION_ENABLE_STATE(en_st),
        .SGMII_MODE(sgmii), .LOCAL_PAGE_SENT(sent), .LOCAL_PAGE_WORD(lpw), .IRQ(irq));
    function automatic logic [31:0] loc_exp(logic [15:0] v, logic t);
        return {16'h0, v & FAPR_LOCNP_WR_MASK | {4'h0, t, 11'h0}};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= FAPR_HTRANS_NONSEQ;
        hwrite <= wr;
        haddr  <= {18'h0, idx, 2'h0};
        do @(posedge mclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0, d);
        check(d, exp);
        check({31'h0, hresp}, 32'h0);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        #100us;
        n_mismatch++;
        final_report();
    end
    initial begin
        {resetn, hsel, hwrite, en_st, sgmii, sent, tog, np} = '0;
        haddr = '0; hwdata = '0; htrans = '0;
        seed = 32'h0397;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        rdchk(FAPR_ABIL_IDX, 32'h0);
        rdchk(FAPR_EXP_IDX, 32'h4);
        rdchk(FAPR_LOCNP_IDX, 32'h2001);
        rdchk(FAPR_LPNP_IDX, 32'h0);
        rdchk(12'hc10, 32'h0);
        for (i = 0; i < 6; i++) begin
            w = $random(seed);
            bus(1'b1, FAPR_LOCNP_IDX, {16'h0, w[15:0]}, d);
            if (i[0]) begin
                sent <= 1'b1;
                @(posedge mclk);
                sent <= 1'b0;
                tog = ~tog;
            end
            rdchk(FAPR_LOCNP_IDX, loc_exp(w[15:0], tog));
            check({16'h0, lpw}, loc_exp(w[15:0], tog));
        end
        for (i = 0; i < 8; i++) begin
            sg = (i >= 4);
            sgmii <= sg;
            @(posedge mclk);
            w = $random(seed);
            w[13:12] = i[1:0];
            if (i == 1) w[15] = 1'b1;
            fapr_partner_i.send(1'b0, w[15:0]);
            if (sg) w[15] = 1'b0;
            np = np | w[15];
            rdchk(FAPR_ABIL_IDX, w & FAPR_ABIL_MASK);
            rdchk(FAPR_EXP_IDX, {28'h0, np, !sg, 2'h3});
            rdchk(FAPR_EXP_IDX, {28'h0, np, !sg, 2'h1});
        end
        en_st <= 1'b1;
        @(posedge mclk);
        en_st <= 1'b0;
        rdchk(FAPR_EXP_IDX, 32'h0);
        bus(1'b1, FAPR_IMSK_IDX, 32'h2, d);
        for (i = 0; i < 4; i++) begin
            w = $random(seed);
            fapr_partner_i.send(1'b1, w[15:0]);
            rdchk(FAPR_LPNP_IDX, w & FAPR_LPNP_MASK);
            rdchk(FAPR_EXP_IDX, 32'h2);
            check({31'h0, irq}, 32'h1);
        end
        rdchk(FAPR_ISTS_IDX, 32'h3);
        bus(1'b1, FAPR_ISTS_IDX, 32'h2, d);
        rdchk(FAPR_ISTS_IDX, 32'h1);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, FAPR_ISTS_IDX, 32'h1, d);
        rdchk(FAPR_ISTS_IDX, 32'h0);
        final_report();
    end
endmodule
